// ==== tcap_pkg.sv ====
// Purpose: Shared constants and types of the 16-bit timer with input capture
// Assumes: 8-bit CPU I/O access with one-cycle read and write strobes
// Notes:   Register indices are the I/O locations seen by the CPU
package tcap_pkg;

	// I/O locations
	localparam logic [3:0] ADDR_CNT_L  = 4'h0;
	localparam logic [3:0] ADDR_CNT_H  = 4'h1;
	localparam logic [3:0] ADDR_CAP_L  = 4'h2;
	localparam logic [3:0] ADDR_CAP_H  = 4'h3;
	localparam logic [3:0] ADDR_CTRL_A = 4'h4;
	localparam logic [3:0] ADDR_CTRL_B = 4'h5;
	localparam logic [3:0] ADDR_FLAGS  = 4'h6;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
	localparam logic [3:0] ADDR_CMP    = 4'h8;

	// Field positions
	localparam int CTRL_B_EDGE   = 6;
	localparam int CTRL_B_FILTER = 7;
	localparam int FLAG_OVF      = 0;
	localparam int FLAG_CAP      = 5;
	localparam int CMP_SEL       = 3;
	localparam int CMP_OUT       = 5;

	// Counter limits
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hffff;
	localparam logic [15:0] TOP_8      = 16'h00ff;
	localparam logic [15:0] TOP_9      = 16'h01ff;
	localparam logic [15:0] TOP_10     = 16'h03ff;

	// Clock select codes and prescaler masks
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [9:0] PRE_MASK_8    = 10'h007;
	localparam logic [9:0] PRE_MASK_64   = 10'h03f;
	localparam logic [9:0] PRE_MASK_256  = 10'h0ff;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

	// Reset values
	localparam logic [7:0]  REG_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	// Counting sequence kinds
	typedef enum logic [1:0] {
		KIND_NORMAL = 2'b00,
		KIND_CTC    = 2'b01,
		KIND_FAST   = 2'b10,
		KIND_PHASE  = 2'b11
	} tcap_kind_type;

	typedef struct packed {
		tcap_kind_type kind;
		logic [15:0]   top;
		logic          cap_is_top;
	} tcap_mode_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} tcap_io_req_type;

endpackage

// ==== tcap_noise_filter.sv ====
// Purpose: Four-sample noise filter in front of the capture edge detector
// Assumes: level_i is already synchronised to clk_i
// Notes:   Bypassed when disabled; samples on every system clock
`timescale 1ns/10ps
module tcap_noise_filter (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Filter control and data
	input  wire logic enable_i,
	input  wire logic level_i,
	output logic      level_o
);

	logic [3:0] samples_reg;
	logic       agree;

	// Sampled on the system clock, so prescaling never slows the filter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			samples_reg <= 4'h0;
		end else begin
			samples_reg <= {samples_reg[2:0], level_i};
		end
	end

	assign agree = (samples_reg == 4'hf) || (samples_reg == 4'h0);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= 1'b0;
		end else if (!enable_i) begin
			level_o <= level_i;
		end else if (agree) begin
			level_o <= samples_reg[0];
		end
	end

	sequence s_held_back;
		enable_i && !agree;
	endsequence

	property p_change_needs_agree;
		@(posedge clk_i) disable iff (!rstn_i)
		s_held_back |=> $stable(level_o);
	endproperty

	a_filter_agree_change: assert property (p_change_needs_agree)
		else $error("Filter output changed without four agreeing samples");

endmodule // tcap_noise_filter

// ==== tcap_timer.sv ====
// Purpose: 16-bit up/down timer with overflow flag and input capture
// Assumes: CPU uses one-cycle rd/wr strobes; pins are asynchronous
// Notes:   Output compare and waveform outputs live elsewhere
`timescale 1ns/10ps

module tcap_timer (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rstn_i,
	// CPU I/O access
	input  wire tcap_pkg::tcap_io_req_type io_req_i,
	output logic [7:0]                     io_rdata_o,
	// Interrupt service acknowledges
	input  wire logic                      capture_irq_ack_i,
	input  wire logic                      overflow_irq_ack_i,
	// Pins
	input  wire logic                      capture_pin_i,
	input  wire logic                      comparator_output_i,
	input  wire logic                      external_count_pin_i,
	// Interrupts and counter status
	output logic                           capture_irq_o,
	output logic                           overflow_irq_o,
	output logic                           top_o,
	output logic                           bottom_o
);

	logic [15:0]              count_value_reg;
	logic [15:0]              count_value_next;
	logic [15:0]              capture_value_reg;
	logic [7:0]               temp_reg;
	logic [7:0]               timer_control_a_reg;
	logic [7:0]               timer_control_b_reg;
	logic [7:0]               irq_enable_reg;
	logic                     comparator_capture_select_reg;
	logic                     capture_flag_reg;
	logic                     capture_flag_next;
	logic                     overflow_flag_reg;
	logic                     overflow_flag_next;
	logic                     dir_up_reg;
	logic                     dir_up_next;
	logic [9:0]               presc_reg;
	logic [2:0]               sync1_reg;
	logic [2:0]               sync2_reg;
	logic                     ext_prev_reg;
	logic                     filt_prev_reg;
	logic                     filt_level;
	logic                     timer_tick;
	logic                     capture_fire;
	logic                     overflow_hit;
	logic [2:0]               timer_clock_select;
	logic [3:0]               waveform_mode_sel;
	tcap_pkg::tcap_mode_type  mode;
	logic                     wr_cnt_l;
	logic                     wr_cap_l;
	logic                     rd_cnt_l;
	logic                     rd_cap_l;

	assign timer_clock_select = timer_control_b_reg[2:0];
	assign waveform_mode_sel  = {timer_control_b_reg[4:3], timer_control_a_reg[1:0]};
	assign wr_cnt_l = io_req_i.wr && io_req_i.addr == tcap_pkg::ADDR_CNT_L;
	assign wr_cap_l = io_req_i.wr && io_req_i.addr == tcap_pkg::ADDR_CAP_L;
	assign rd_cnt_l = io_req_i.rd && io_req_i.addr == tcap_pkg::ADDR_CNT_L;
	assign rd_cap_l = io_req_i.rd && io_req_i.addr == tcap_pkg::ADDR_CAP_L;

	// Decode of the waveform mode into sequence kind and top value
	function automatic tcap_pkg::tcap_mode_type decode_mode(
		input logic [3:0]  sel,
		input logic [15:0] cap
	);
		tcap_pkg::tcap_mode_type m;
		m = '{tcap_pkg::KIND_NORMAL, tcap_pkg::CNT_MAX, 1'b0};
		unique case (sel)
			4'h1: m = '{tcap_pkg::KIND_PHASE, tcap_pkg::TOP_8, 1'b0};
			4'h2: m = '{tcap_pkg::KIND_PHASE, tcap_pkg::TOP_9, 1'b0};
			4'h3: m = '{tcap_pkg::KIND_PHASE, tcap_pkg::TOP_10, 1'b0};
			4'h5: m = '{tcap_pkg::KIND_FAST, tcap_pkg::TOP_8, 1'b0};
			4'h6: m = '{tcap_pkg::KIND_FAST, tcap_pkg::TOP_9, 1'b0};
			4'h7: m = '{tcap_pkg::KIND_FAST, tcap_pkg::TOP_10, 1'b0};
			4'h8: m = '{tcap_pkg::KIND_PHASE, cap, 1'b1};
			4'ha: m = '{tcap_pkg::KIND_PHASE, cap, 1'b1};
			4'hc: m = '{tcap_pkg::KIND_CTC, cap, 1'b1};
			4'he: m = '{tcap_pkg::KIND_FAST, cap, 1'b1};
			// Modes whose top lives in the compare unit count as normal here
			default: m = '{tcap_pkg::KIND_NORMAL, tcap_pkg::CNT_MAX, 1'b0};
		endcase
		return m;
	endfunction

	assign mode = decode_mode(waveform_mode_sel, capture_value_reg);

	// Two-stage synchronisers: capture pin, comparator, external count pin
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {external_count_pin_i, comparator_output_i, capture_pin_i};
			sync2_reg <= sync1_reg;
		end
	end

	// Prescaler and tick selection
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			presc_reg    <= 10'h000;
			ext_prev_reg <= 1'b0;
		end else begin
			presc_reg    <= presc_reg + 10'h001;
			ext_prev_reg <= sync2_reg[2];
		end
	end

	always_comb begin
		unique case (timer_clock_select)
			tcap_pkg::CS_STOP:     timer_tick = 1'b0;
			tcap_pkg::CS_DIV1:     timer_tick = 1'b1;
			tcap_pkg::CS_DIV8:     timer_tick = (presc_reg & tcap_pkg::PRE_MASK_8) == 10'h000;
			tcap_pkg::CS_DIV64:    timer_tick = (presc_reg & tcap_pkg::PRE_MASK_64) == 10'h000;
			tcap_pkg::CS_DIV256:   timer_tick = (presc_reg & tcap_pkg::PRE_MASK_256) == 10'h000;
			tcap_pkg::CS_DIV1024:  timer_tick = (presc_reg & tcap_pkg::PRE_MASK_1024) == 10'h000;
			tcap_pkg::CS_EXT_FALL: timer_tick = ext_prev_reg && !sync2_reg[2];
			default:               timer_tick = !ext_prev_reg && sync2_reg[2];
		endcase
	end

	// Counter sequence; a CPU write of the low counter byte overrides every count action
	always_comb begin
		count_value_next = count_value_reg;
		dir_up_next      = dir_up_reg;
		overflow_hit     = 1'b0;
		if (wr_cnt_l) begin
			count_value_next = {temp_reg, io_req_i.wdata};
		end else if (timer_tick) begin
			unique case (mode.kind)
				tcap_pkg::KIND_NORMAL: begin
					count_value_next = count_value_reg + 16'h0001;
					overflow_hit     = count_value_reg == tcap_pkg::CNT_MAX;
				end
				tcap_pkg::KIND_CTC: begin
					count_value_next = (count_value_reg == mode.top) ?
						tcap_pkg::CNT_BOTTOM : count_value_reg + 16'h0001;
					overflow_hit     = count_value_reg == tcap_pkg::CNT_MAX;
				end
				tcap_pkg::KIND_FAST: begin
					count_value_next = (count_value_reg >= mode.top) ?
						tcap_pkg::CNT_BOTTOM : count_value_reg + 16'h0001;
					overflow_hit     = count_value_reg == mode.top;
				end
				tcap_pkg::KIND_PHASE: begin
					if (dir_up_reg && count_value_reg >= mode.top) begin
						count_value_next = count_value_reg - 16'h0001;
						dir_up_next      = 1'b0;
					end else if (dir_up_reg) begin
						count_value_next = count_value_reg + 16'h0001;
					end else if (count_value_reg == tcap_pkg::CNT_BOTTOM) begin
						count_value_next = count_value_reg + 16'h0001;
						dir_up_next      = 1'b1;
						overflow_hit     = 1'b1;
					end else begin
						count_value_next = count_value_reg - 16'h0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_value_reg <= tcap_pkg::CNT_RESET;
			dir_up_reg      <= 1'b1;
		end else begin
			count_value_reg <= count_value_next;
			dir_up_reg      <= dir_up_next;
		end
	end

	// Top and bottom indications follow the counter register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			top_o    <= 1'b0;
			bottom_o <= 1'b1;
		end else begin
			top_o    <= count_value_next == mode.top;
			bottom_o <= count_value_next == tcap_pkg::CNT_BOTTOM;
		end
	end

	// Capture source, filter and edge detector
	tcap_noise_filter u_filter (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.enable_i (timer_control_b_reg[tcap_pkg::CTRL_B_FILTER]),
		.level_i  (comparator_capture_select_reg ? sync2_reg[1] : sync2_reg[0]),
		.level_o  (filt_level)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			filt_prev_reg <= 1'b0;
		end else begin
			filt_prev_reg <= filt_level;
		end
	end

	// A source switch can look like an edge; software clears the flag after
	assign capture_fire = !mode.cap_is_top &&
		(timer_control_b_reg[tcap_pkg::CTRL_B_EDGE] ?
			(filt_level && !filt_prev_reg) : (!filt_level && filt_prev_reg));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			capture_value_reg <= tcap_pkg::CNT_RESET;
		end else if (capture_fire) begin
			capture_value_reg <= count_value_reg;
		end else if (wr_cap_l && mode.cap_is_top) begin
			capture_value_reg <= {temp_reg, io_req_i.wdata};
		end
	end

	// Flags: a hardware set wins over a same-cycle clear
	assign capture_flag_next = capture_fire || (capture_flag_reg && !capture_irq_ack_i &&
		!(io_req_i.wr && io_req_i.addr == tcap_pkg::ADDR_FLAGS &&
		io_req_i.wdata[tcap_pkg::FLAG_CAP]));
	assign overflow_flag_next = overflow_hit || (overflow_flag_reg && !overflow_irq_ack_i &&
		!(io_req_i.wr && io_req_i.addr == tcap_pkg::ADDR_FLAGS &&
		io_req_i.wdata[tcap_pkg::FLAG_OVF]));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			capture_flag_reg  <= 1'b0;
			overflow_flag_reg <= 1'b0;
		end else begin
			capture_flag_reg  <= capture_flag_next;
			overflow_flag_reg <= overflow_flag_next;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			capture_irq_o  <= 1'b0;
			overflow_irq_o <= 1'b0;
		end else begin
			capture_irq_o  <= capture_flag_reg && irq_enable_reg[tcap_pkg::FLAG_CAP];
			overflow_irq_o <= overflow_flag_reg && irq_enable_reg[tcap_pkg::FLAG_OVF];
		end
	end

	// Shared high-byte temporary register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			temp_reg <= tcap_pkg::REG_RESET;
		end else if (io_req_i.wr && (io_req_i.addr == tcap_pkg::ADDR_CNT_H ||
				io_req_i.addr == tcap_pkg::ADDR_CAP_H)) begin
			temp_reg <= io_req_i.wdata;
		end else if (rd_cnt_l) begin
			temp_reg <= count_value_reg[15:8];
		end else if (rd_cap_l) begin
			temp_reg <= capture_value_reg[15:8];
		end
	end

	// Control registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_control_a_reg           <= tcap_pkg::REG_RESET;
			timer_control_b_reg           <= tcap_pkg::REG_RESET;
			irq_enable_reg                <= tcap_pkg::REG_RESET;
			comparator_capture_select_reg <= 1'b0;
		end else if (io_req_i.wr) begin
			unique case (io_req_i.addr)
				tcap_pkg::ADDR_CTRL_A: timer_control_a_reg <= io_req_i.wdata;
				tcap_pkg::ADDR_CTRL_B: timer_control_b_reg <= io_req_i.wdata;
				tcap_pkg::ADDR_IRQ_EN: irq_enable_reg <= io_req_i.wdata;
				tcap_pkg::ADDR_CMP:
					comparator_capture_select_reg <= io_req_i.wdata[tcap_pkg::CMP_SEL];
				default: ;
			endcase
		end
	end

	// Read data is registered; both high-byte locations return the temp
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_rdata_o <= tcap_pkg::REG_RESET;
		end else if (io_req_i.rd) begin
			unique case (io_req_i.addr)
				tcap_pkg::ADDR_CNT_L:  io_rdata_o <= count_value_reg[7:0];
				tcap_pkg::ADDR_CNT_H:  io_rdata_o <= temp_reg;
				tcap_pkg::ADDR_CAP_L:  io_rdata_o <= capture_value_reg[7:0];
				tcap_pkg::ADDR_CAP_H:  io_rdata_o <= temp_reg;
				tcap_pkg::ADDR_CTRL_A: io_rdata_o <= timer_control_a_reg;
				tcap_pkg::ADDR_CTRL_B: io_rdata_o <= timer_control_b_reg;
				tcap_pkg::ADDR_FLAGS: begin
					io_rdata_o <= tcap_pkg::REG_RESET;
					io_rdata_o[tcap_pkg::FLAG_CAP] <= capture_flag_reg;
					io_rdata_o[tcap_pkg::FLAG_OVF] <= overflow_flag_reg;
				end
				tcap_pkg::ADDR_IRQ_EN: io_rdata_o <= irq_enable_reg;
				tcap_pkg::ADDR_CMP: begin
					io_rdata_o <= tcap_pkg::REG_RESET;
					io_rdata_o[tcap_pkg::CMP_SEL] <= comparator_capture_select_reg;
					io_rdata_o[tcap_pkg::CMP_OUT] <= sync2_reg[1];
				end
				default: io_rdata_o <= tcap_pkg::REG_RESET;
			endcase
		end
	end

	// Checks
	a_stopped_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(timer_clock_select == tcap_pkg::CS_STOP && !wr_cnt_l)
			|=> $stable(count_value_reg))
		else $error("Stopped counter changed");

	a_cnt_write_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_cnt_l |=> count_value_reg == {$past(temp_reg), $past(io_req_i.wdata)})
		else $error("Counter write did not load temp and low byte");

	sequence s_low_read;
		rd_cnt_l && !io_req_i.wr;
	endsequence

	a_low_read_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_low_read ##1 (io_req_i.rd && io_req_i.addr == tcap_pkg::ADDR_CNT_H && !io_req_i.wr)
			|=> io_rdata_o == $past(count_value_reg[15:8], 2))
		else $error("High byte read did not return latched counter byte");

	a_capture_stamp: assert property (@(posedge clk_i) disable iff (!rstn_i)
		capture_fire |=> capture_flag_reg && capture_value_reg == $past(count_value_reg))
		else $error("Capture flag and value not updated together");

	a_flag_zero_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(io_req_i.wr && io_req_i.addr == tcap_pkg::ADDR_FLAGS &&
			!io_req_i.wdata[tcap_pkg::FLAG_CAP] && !capture_irq_ack_i)
			|=> capture_flag_reg == $past(capture_flag_reg) || capture_flag_reg)
		else $error("Writing zero cleared the capture flag");

	a_irq_follows_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(capture_flag_reg && irq_enable_reg[tcap_pkg::FLAG_CAP]) |=> capture_irq_o)
		else $error("Enabled capture flag raised no request");

	a_bottom_matches: assert property (@(posedge clk_i) disable iff (!rstn_i)
		bottom_o == (count_value_reg == tcap_pkg::CNT_BOTTOM))
		else $error("Bottom indication disagrees with counter");

	a_top_mode_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(mode.cap_is_top && !wr_cap_l) |=> $stable(capture_value_reg))
		else $error("Capture value moved while it defines top");

endmodule // tcap_timer

// ==== tcap_cpu_model.sv ====
// Purpose: CPU and pin model on the far side of the timer
// Assumes: Requests change 1 ns after a rising edge and are taken at the next edge
// Notes:   Writes end with an idle cycle so a held strobe never repeats a write
`timescale 1ns/10ps
module tcap_cpu_model (
	// Clock
	input  wire logic                 clk_i,
	// CPU I/O access
	output tcap_pkg::tcap_io_req_type io_req_o,
	input  wire logic [7:0]           io_rdata_i,
	// Pins and acknowledges
	output logic                      capture_pin_o,
	output logic                      comparator_output_o,
	output logic                      external_count_pin_o,
	output logic                      capture_irq_ack_o,
	output logic                      overflow_irq_ack_o
);
	initial begin
		io_req_o = '0;
		capture_pin_o = 1'b0;
		comparator_output_o = 1'b0;
		external_count_pin_o = 1'b0;
		capture_irq_ack_o = 1'b0;
		overflow_irq_ack_o = 1'b0;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Request held through the taking edge; read data lands at that edge
	task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] d,
			output logic [7:0] q);
		io_req_o = '{rd: rd, wr: !rd, addr: a, wdata: d};
		wait_cyc(1);
		q = io_rdata_i;
	endtask
	task automatic idle();
		io_req_o = '0;
		wait_cyc(1);
	endtask
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(1'b0, a, d, q);
		idle();
	endtask
	task automatic rd8(input logic [3:0] a, output logic [7:0] q);
		access(1'b1, a, 8'h00, q);
		idle();
	endtask
	// High byte first, low byte moves the whole word
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		logic [7:0] q;
		access(1'b0, a | 4'h1, v[15:8], q);
		access(1'b0, a, v[7:0], q);
		idle();
	endtask
	// Low byte first, it latches the high byte into the shared temp
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		access(1'b1, a, 8'h00, v[7:0]);
		access(1'b1, a | 4'h1, 8'h00, v[15:8]);
		idle();
	endtask
	task automatic set_pins(input logic cap, input logic cmp);
		capture_pin_o = cap;
		comparator_output_o = cmp;
	endtask
	task automatic ack(input logic cap, input logic ovf);
		capture_irq_ack_o = cap;
		overflow_irq_ack_o = ovf;
		wait_cyc(1);
		capture_irq_ack_o = 1'b0;
		overflow_irq_ack_o = 1'b0;
	endtask
	// Each level lasts two clocks so the synchroniser sees every edge
	task automatic pulse_ext(input int n);
		repeat (n) begin
			external_count_pin_o = 1'b1;
			wait_cyc(2);
			external_count_pin_o = 1'b0;
			wait_cyc(2);
		end
	endtask
endmodule // tcap_cpu_model

// ==== tb_timer16_counter_input_capture.sv ====
// Purpose: Self-checking bench of the timer with input capture
// Assumes: Register map and latencies as the designer chose them
// Notes:   Capture latency is compared filtered against unfiltered
`timescale 1ns/10ps
module tb_timer16_counter_input_capture;
	logic                      clk_i, rstn_i;
	tcap_pkg::tcap_io_req_type io_req;
	logic [7:0]                io_rdata;
	logic                      cap_pin, cmp_out, ext_pin, cap_ack, ovf_ack;
	logic                      cap_irq, ovf_irq, top, bottom;
	int                        error_cnt = 0;
	int                        checks_done = 0;
	int                        lat_raw;
	tcap_cpu_model cpu (.clk_i(clk_i), .io_req_o(io_req), .io_rdata_i(io_rdata),
		.capture_pin_o(cap_pin), .comparator_output_o(cmp_out),
		.external_count_pin_o(ext_pin), .capture_irq_ack_o(cap_ack),
		.overflow_irq_ack_o(ovf_ack));
	tcap_timer dut (.clk_i(clk_i), .rstn_i(rstn_i), .io_req_i(io_req), .io_rdata_o(io_rdata),
		.capture_irq_ack_i(cap_ack), .overflow_irq_ack_i(ovf_ack),
		.capture_pin_i(cap_pin), .comparator_output_i(cmp_out),
		.external_count_pin_i(ext_pin), .capture_irq_o(cap_irq),
		.overflow_irq_o(ovf_irq), .top_o(top), .bottom_o(bottom));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Cycles until the capture interrupt shows, or -1 when the bound runs out
	task automatic wait_cap(input int bound, output int n);
		n = -1;
		for (int i = 1; i <= bound && n < 0; i++) begin
			cpu.wait_cyc(1);
			if (cap_irq === 1'b1) n = i;
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic s_access();
		logic [15:0] v;
		logic [7:0]  b;
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h01ff);
		cpu.wait_cyc(20);
		cpu.rd16(tcap_pkg::ADDR_CNT_L, v);
		check("stopped count", 16'h01ff, v);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'hffff);
		cpu.wait_cyc(2);
		check("top", 16'h1, top);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h0000);
		cpu.wait_cyc(2);
		check("bottom", 16'h1, bottom);
		cpu.rd8(4'hf, b);
		check("unmapped read", 16'h0, b);
	endtask
	task automatic s_count();
		logic [15:0] v;
		int          n;
		cpu.wr8(tcap_pkg::ADDR_IRQ_EN, 8'h21);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'hfff0);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h01);
		n = 0;
		while (ovf_irq !== 1'b1 && n < 40) begin
			cpu.wait_cyc(1);
			n++;
		end
		check("overflow irq", 16'h1, ovf_irq);
		cpu.ack(1'b0, 1'b1);
		cpu.wait_cyc(2);
		check("overflow ack", 16'h0, ovf_irq);
		// A running counter moves a few ticks between write and read
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h1234);
		cpu.rd16(tcap_pkg::ADDR_CNT_L, v);
		check("running write", 16'h1, v >= 16'h1234 && v < 16'h123c);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
	endtask
	task automatic s_capture();
		logic [15:0] v;
		int          n;
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h40);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h21);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h4321);
		cpu.set_pins(1'b1, 1'b0);
		wait_cap(12, lat_raw);
		check("rising capture", 16'h1, lat_raw > 0);
		cpu.rd16(tcap_pkg::ADDR_CAP_L, v);
		check("captured", 16'h4321, v);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h00);
		cpu.wait_cyc(2);
		check("zero write keeps flag", 16'h1, cap_irq);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h20);
		cpu.wait_cyc(2);
		check("one write clears flag", 16'h0, cap_irq);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h5678);
		cpu.set_pins(1'b0, 1'b0);
		wait_cap(12, n);
		check("falling ignored", 16'h1, n < 0);
		cpu.set_pins(1'b1, 1'b0);
		wait_cap(12, n);
		cpu.rd16(tcap_pkg::ADDR_CAP_L, v);
		check("overwrite", 16'h5678, v);
		cpu.ack(1'b1, 1'b0);
		cpu.wait_cyc(2);
		check("service clears", 16'h0, cap_irq);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h20);
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h9abc);
		cpu.set_pins(1'b0, 1'b0);
		wait_cap(12, n);
		cpu.rd16(tcap_pkg::ADDR_CAP_L, v);
		check("falling capture", 16'h9abc, v);
	endtask
	task automatic s_filter();
		int n;
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'hc0);
		cpu.wr8(tcap_pkg::ADDR_CMP, 8'h08);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h20);
		cpu.set_pins(1'b0, 1'b1);
		cpu.wait_cyc(3);
		cpu.set_pins(1'b0, 1'b0);
		wait_cap(12, n);
		check("glitch rejected", 16'h1, n < 0);
		cpu.set_pins(1'b1, 1'b0);
		wait_cap(12, n);
		check("pin unselected", 16'h1, n < 0);
		cpu.set_pins(1'b0, 1'b1);
		wait_cap(20, n);
		check("filter delay", 16'h4, 16'(n - lat_raw));
		cpu.wr8(tcap_pkg::ADDR_CMP, 8'h00);
		cpu.set_pins(1'b0, 1'b0);
	endtask
	task automatic s_cap_top();
		logic [15:0] v;
		int          n;
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h58);
		cpu.wr8(tcap_pkg::ADDR_FLAGS, 8'h20);
		cpu.wr16(tcap_pkg::ADDR_CAP_L, 16'h1234);
		cpu.rd16(tcap_pkg::ADDR_CAP_L, v);
		check("capture as top", 16'h1234, v);
		cpu.set_pins(1'b1, 1'b0);
		wait_cap(12, n);
		check("no capture at top", 16'h1, n < 0);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
		cpu.wr16(tcap_pkg::ADDR_CAP_L, 16'h9999);
		cpu.rd16(tcap_pkg::ADDR_CAP_L, v);
		check("write refused", 16'h1234, v);
	endtask
	task automatic s_ext();
		logic [15:0] v;
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h0000);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h07);
		cpu.pulse_ext(3);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h06);
		cpu.pulse_ext(2);
		cpu.wait_cyc(4);
		cpu.rd16(tcap_pkg::ADDR_CNT_L, v);
		check("external count", 16'h0005, v);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
	endtask
	task automatic s_phase();
		logic [15:0] v;
		cpu.wr16(tcap_pkg::ADDR_CNT_L, 16'h00fd);
		cpu.wr8(tcap_pkg::ADDR_CTRL_A, 8'h01);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h01);
		cpu.wait_cyc(4);
		cpu.rd16(tcap_pkg::ADDR_CNT_L, v);
		check("phase turn at top", 16'h00fc, v);
		cpu.wr8(tcap_pkg::ADDR_CTRL_B, 8'h00);
	endtask
	initial begin
		rstn_i = 1'b0;
		repeat (12) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		s_access();
		s_count();
		s_capture();
		s_filter();
		s_cap_top();
		s_ext();
		s_phase();
		close_out();
	end
	initial begin
		#900000;
		error_cnt++;
		close_out();
	end
endmodule // tb_timer16_counter_input_capture
